// ### clk_out_pkg.sv
package clk_out_pkg;
    // register indices (byte-free word addresses on the plain port)
    localparam logic [7:0] ADDR_SOFT_RST = 8'h1c;
    localparam logic [7:0] ADDR_HARD_RST = 8'h1e;
    localparam logic [7:0] ADDR_ENABLE = 8'h20;
    localparam logic [7:0] ADDR_POWERDOWN = 8'h21;
    localparam logic [7:0] ADDR_IDLE_LEVEL = 8'h22;
    localparam logic [7:0] ADDR_SYNC_GATE = 8'h23;
    localparam logic [7:0] ADDR_SE_MODE = 8'h24;
    localparam logic [7:0] ADDR_POL_TRUE = 8'h25;
    localparam logic [7:0] ADDR_POL_COMP = 8'h26;
    localparam logic [7:0] ADDR_AUTO_CTRL = 8'h27;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_STEP = 8'h29;
    localparam logic [7:0] ADDR_DELAY0 = 8'h30;
    localparam logic [7:0] ADDR_ACTIVE0 = 8'h38;
    localparam logic [7:0] ADDR_STEPCNT0 = 8'h40;
    // field positions
    localparam int SOFT_RST_BIT = 0;
    localparam int HARD_RST_BIT = 1;
    localparam int AUTO_LOL_EN_BIT = 0;
    localparam int AUTO_XTAL_EN_BIT = 1;
    localparam int STEP_DIR_BIT = 8;
    // reset values
    localparam logic [31:0] ENABLE_RST = 32'hffffffff;
    localparam logic [31:0] ZERO_RST = 32'h00000000;
    localparam logic [1:0] AUTO_CTRL_RST = 2'h2;
    // delay range +/-8.6 ns; signed 16-bit settings cover it
    localparam int DELAY_W = 16;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef enum logic [1:0] {
        DRV_OFF = 2'b00,
        DRV_IDLE = 2'b01,
        DRV_RUN = 2'b10
    } drv_state_e;
endpackage : clk_out_pkg

// ### clock_output_enable_and_skew.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - global disable pin low leaves each driver to its other controls, high disables all.
// - any one active disable source disables its output regardless of enables.
// - each driver independently runs, idles static, or is powered down.
// - powerdown drives neither pin, so both float high-impedance.
// - per-output setting picks idle level low or high while disabled.
// - idle level applies to differential and LVPECL-style formats.
// - synchronous gating waits for the clock period end before changing.
// - asynchronous gating applies enable changes immediately.
// - gating choice governs manual and automatic transitions alike.
// - unlocked loop keeps clocking unless option disables its outputs.
// - crystal reference loss disables all outputs by default.
// - each automatic source maskable; unmasked sources combine wired-OR.
// - single-ended driver clocks both true and complement pins.
// - single-ended complement in phase by default; polarity per pin settable.
// - single-ended polarity settings ignored in differential mode.
// - static skew only for outputs derived from loop B.
// - small variant delays dividers 1 and 4; large variant dividers 1-4.
// - default delays leave all loop B outputs time-aligned.
// - delay bidirectional; step VCO/256 fractional, one VCO period integer.
// - written delays become active only on soft reset.
// - power-on, restart pin or hard reset reload stored delays.
// - phase step any time, shared per divider, cleared by power-on, restart pin or hard reset.
module clock_output_enable_and_skew
    import clk_out_pkg::*;
#(
    parameter int NUM_OUT = 12,
    parameter int NUM_DIV = 4,
    parameter bit LARGE_VARIANT = 1'b1,
    parameter logic [NUM_DIV*DELAY_W-1:0] NVM_DELAY = '0
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic EXTERNAL_RESTART_PIN_N,
    input wire logic GLOBAL_OUTPUT_DISABLE_PIN,
    input wire logic [NUM_OUT-1:0] DIV_CLK,
    input wire logic [NUM_OUT-1:0] FROM_LOOP_B,
    input wire logic [NUM_OUT-1:0] DIFF_FORMAT,
    input wire logic LOOP_UNLOCKED_FLAG,
    input wire logic CRYSTAL_REF_LOSS_FAULT,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic [NUM_OUT-1:0] OUT_TRUE,
    output logic [NUM_OUT-1:0] OUT_TRUE_OE,
    output logic [NUM_OUT-1:0] COMPLEMENT_OUTPUT_PIN,
    output logic [NUM_OUT-1:0] COMPLEMENT_OUTPUT_PIN_OE,
    output logic [NUM_OUT-1:0] DRIVER_ENABLED,
    output logic [NUM_DIV*DELAY_W-1:0] DIVIDER_SKEW_SETTING,
    output logic [NUM_DIV*DELAY_W-1:0] DIVIDER_PHASE_STEPS
);
    logic [NUM_OUT-1:0] enable_reg;
    logic [NUM_OUT-1:0] powerdown_reg;
    logic [NUM_OUT-1:0] idle_level_select;
    logic [NUM_OUT-1:0] sync_gate_reg;
    logic [NUM_OUT-1:0] se_mode_reg;
    logic [NUM_OUT-1:0] pol_true_reg;
    logic [NUM_OUT-1:0] pol_comp_reg;
    logic [1:0] auto_ctrl_reg;
    logic [DELAY_W-1:0] divider_io_skew_setting [NUM_DIV];
    logic [DELAY_W-1:0] skew_active_reg [NUM_DIV];
    logic [DELAY_W-1:0] step_cnt_reg [NUM_DIV];
    logic [NUM_OUT-1:0] run_reg;
    logic [NUM_OUT-1:0] div_clk_d_reg;
    logic [NUM_OUT-1:0] want_run;
    logic auto_disable;
    logic hard_clear;
    logic [31:0] rdata_next;

    // divider exists for skew in this variant
    function automatic logic div_has_delay(input int idx);
        div_has_delay = LARGE_VARIANT ? (idx < 4) : (idx == 0 || idx == 3);
    endfunction : div_has_delay

    // write strobe aimed at one register word; inputs passed so assigns stay sensitive
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
            input logic [7:0] target);
        wr_hit = wr && (addr == target);
    endfunction : wr_hit

    // unmasked automatic sources are OR-ed; pin and manual bits each veto
    assign auto_disable = (auto_ctrl_reg[AUTO_LOL_EN_BIT] & LOOP_UNLOCKED_FLAG)
        | (auto_ctrl_reg[AUTO_XTAL_EN_BIT] & CRYSTAL_REF_LOSS_FAULT);
    assign want_run = enable_reg & ~powerdown_reg
        & {NUM_OUT{~GLOBAL_OUTPUT_DISABLE_PIN & ~auto_disable}};

    assign hard_clear = ~EXTERNAL_RESTART_PIN_N
        | (wr_hit(WR, ADDR, ADDR_HARD_RST) & WDATA[HARD_RST_BIT]);

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            div_clk_d_reg <= '0;
        end else if (CLK_EN) begin
            div_clk_d_reg <= DIV_CLK;
        end
    end

    // sync gating changes only at the falling edge ending a period
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            run_reg <= '0;
        end else if (CLK_EN) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (!sync_gate_reg[i]) begin
                    run_reg[i] <= want_run[i];
                end else if (div_clk_d_reg[i] && !DIV_CLK[i]) begin
                    run_reg[i] <= want_run[i];
                end
            end
        end
    end

    // async path also bypasses the register for immediate stop
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            logic running;
            logic level;
            // powerdown removes the driver at once, never waiting for a period end
            running = (sync_gate_reg[i] ? run_reg[i] : want_run[i]) & ~powerdown_reg[i];
            level = running ? DIV_CLK[i] : idle_level_select[i];
            DRIVER_ENABLED[i] = running;
            OUT_TRUE_OE[i] = ~powerdown_reg[i];
            COMPLEMENT_OUTPUT_PIN_OE[i] = ~powerdown_reg[i];
            if (powerdown_reg[i]) begin
                OUT_TRUE[i] = 1'b0;
                COMPLEMENT_OUTPUT_PIN[i] = 1'b0;
            end else if (se_mode_reg[i] && !DIFF_FORMAT[i]) begin
                OUT_TRUE[i] = level ^ pol_true_reg[i];
                COMPLEMENT_OUTPUT_PIN[i] = level ^ pol_comp_reg[i];
            end else begin
                OUT_TRUE[i] = level;
                COMPLEMENT_OUTPUT_PIN[i] = ~level;
            end
        end
    end

    // one process per control word, so a decode slip touches one word only
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            enable_reg <= ENABLE_RST[NUM_OUT-1:0];
        end else if (CLK_EN && wr_hit(WR, ADDR, ADDR_ENABLE)) begin
            enable_reg <= WDATA[NUM_OUT-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            powerdown_reg <= ZERO_RST[NUM_OUT-1:0];
        end else if (CLK_EN && wr_hit(WR, ADDR, ADDR_POWERDOWN)) begin
            powerdown_reg <= WDATA[NUM_OUT-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            idle_level_select <= ZERO_RST[NUM_OUT-1:0];
        end else if (CLK_EN && wr_hit(WR, ADDR, ADDR_IDLE_LEVEL)) begin
            idle_level_select <= WDATA[NUM_OUT-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            sync_gate_reg <= ENABLE_RST[NUM_OUT-1:0];
        end else if (CLK_EN && wr_hit(WR, ADDR, ADDR_SYNC_GATE)) begin
            sync_gate_reg <= WDATA[NUM_OUT-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            se_mode_reg <= ZERO_RST[NUM_OUT-1:0];
        end else if (CLK_EN && wr_hit(WR, ADDR, ADDR_SE_MODE)) begin
            se_mode_reg <= WDATA[NUM_OUT-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            pol_true_reg <= ZERO_RST[NUM_OUT-1:0];
        end else if (CLK_EN && wr_hit(WR, ADDR, ADDR_POL_TRUE)) begin
            pol_true_reg <= WDATA[NUM_OUT-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            pol_comp_reg <= ZERO_RST[NUM_OUT-1:0];
        end else if (CLK_EN && wr_hit(WR, ADDR, ADDR_POL_COMP)) begin
            pol_comp_reg <= WDATA[NUM_OUT-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            auto_ctrl_reg <= AUTO_CTRL_RST;
        end else if (CLK_EN && wr_hit(WR, ADDR, ADDR_AUTO_CTRL)) begin
            auto_ctrl_reg <= WDATA[1:0];
        end
    end

    // staged delay settings; reload from stored values on hard clear
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            for (int d = 0; d < NUM_DIV; d++) begin
                divider_io_skew_setting[d] <= NVM_DELAY[d*DELAY_W +: DELAY_W];
                skew_active_reg[d] <= NVM_DELAY[d*DELAY_W +: DELAY_W];
            end
        end else if (CLK_EN) begin
            for (int d = 0; d < NUM_DIV; d++) begin
                if (hard_clear) begin
                    divider_io_skew_setting[d] <= NVM_DELAY[d*DELAY_W +: DELAY_W];
                    skew_active_reg[d] <= NVM_DELAY[d*DELAY_W +: DELAY_W];
                end else begin
                    if (wr_hit(WR, ADDR, ADDR_DELAY0 + 8'(d)) && div_has_delay(d)) begin
                        divider_io_skew_setting[d] <= WDATA[DELAY_W-1:0];
                    end
                    if (wr_hit(WR, ADDR, ADDR_SOFT_RST) && WDATA[SOFT_RST_BIT]
                            && div_has_delay(d)) begin
                        skew_active_reg[d] <= divider_io_skew_setting[d];
                    end
                end
            end
        end
    end

    // phase steps accumulate per divider, so all its outputs move together
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            for (int d = 0; d < NUM_DIV; d++) begin
                step_cnt_reg[d] <= '0;
            end
        end else if (CLK_EN) begin
            for (int d = 0; d < NUM_DIV; d++) begin
                if (hard_clear) begin
                    step_cnt_reg[d] <= '0;
                end else if (wr_hit(WR, ADDR, ADDR_STEP) && WDATA[d]) begin
                    step_cnt_reg[d] <= WDATA[STEP_DIR_BIT] ? step_cnt_reg[d] - DELAY_W'(1)
                                                           : step_cnt_reg[d] + DELAY_W'(1);
                end
            end
        end
    end

    // skew is meaningful only on loop B outputs; the fabric routes it there
    always_comb begin
        for (int d = 0; d < NUM_DIV; d++) begin
            DIVIDER_SKEW_SETTING[d*DELAY_W +: DELAY_W] = skew_active_reg[d];
            DIVIDER_PHASE_STEPS[d*DELAY_W +: DELAY_W] = step_cnt_reg[d];
        end
    end

    always_comb begin
        rdata_next = 32'h00000000;
        case (ADDR)
            ADDR_ENABLE: rdata_next[NUM_OUT-1:0] = enable_reg;
            ADDR_POWERDOWN: rdata_next[NUM_OUT-1:0] = powerdown_reg;
            ADDR_IDLE_LEVEL: rdata_next[NUM_OUT-1:0] = idle_level_select;
            ADDR_SYNC_GATE: rdata_next[NUM_OUT-1:0] = sync_gate_reg;
            ADDR_SE_MODE: rdata_next[NUM_OUT-1:0] = se_mode_reg;
            ADDR_POL_TRUE: rdata_next[NUM_OUT-1:0] = pol_true_reg;
            ADDR_POL_COMP: rdata_next[NUM_OUT-1:0] = pol_comp_reg;
            ADDR_AUTO_CTRL: rdata_next[1:0] = auto_ctrl_reg;
            ADDR_STATUS: rdata_next[NUM_OUT-1:0] = DRIVER_ENABLED;
            default: begin
                for (int d = 0; d < NUM_DIV; d++) begin
                    if (ADDR == ADDR_DELAY0 + 8'(d)) begin
                        rdata_next[DELAY_W-1:0] = divider_io_skew_setting[d];
                    end
                    if (ADDR == ADDR_ACTIVE0 + 8'(d)) begin
                        rdata_next[DELAY_W-1:0] = skew_active_reg[d];
                    end
                    if (ADDR == ADDR_STEPCNT0 + 8'(d)) begin
                        rdata_next[DELAY_W-1:0] = step_cnt_reg[d];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            RDATA <= 32'h00000000;
        end else if (CLK_EN) begin
            RDATA <= RD ? rdata_next : 32'h00000000;
        end
    end
endmodule : clock_output_enable_and_skew

// ### clock_output_enable_and_skew_assertions.sv
`timescale 1ns/1ps
module clock_output_enable_and_skew_chk
    import clk_out_pkg::*;
#(
    parameter int NUM_OUT = 12,
    parameter int NUM_DIV = 4
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic EXTERNAL_RESTART_PIN_N,
    input wire logic GLOBAL_OUTPUT_DISABLE_PIN,
    input wire logic [NUM_OUT-1:0] DIFF_FORMAT,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [NUM_OUT-1:0] OUT_TRUE,
    input wire logic [NUM_OUT-1:0] OUT_TRUE_OE,
    input wire logic [NUM_OUT-1:0] COMPLEMENT_OUTPUT_PIN,
    input wire logic [NUM_OUT-1:0] COMPLEMENT_OUTPUT_PIN_OE,
    input wire logic [NUM_OUT-1:0] DRIVER_ENABLED,
    input wire logic [NUM_DIV*DELAY_W-1:0] DIVIDER_SKEW_SETTING,
    input wire logic [NUM_DIV*DELAY_W-1:0] DIVIDER_PHASE_STEPS
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    logic cfg_rst;
    assign cfg_rst = !EXTERNAL_RESTART_PIN_N || (WR && ((ADDR == ADDR_SOFT_RST
        && WDATA[SOFT_RST_BIT]) || (ADDR == ADDR_HARD_RST && WDATA[HARD_RST_BIT])));
    sequence s_rd_status;
        CLK_EN && RD && ADDR == ADDR_STATUS;
    endsequence
    property p_gdis; GLOBAL_OUTPUT_DISABLE_PIN [*8] |-> DRIVER_ENABLED == '0; endproperty
    a_gdis: assert property (p_gdis) else $error("drivers run with disable pin high");
    property p_pdown;
        (OUT_TRUE_OE == COMPLEMENT_OUTPUT_PIN_OE) && ((DRIVER_ENABLED & ~OUT_TRUE_OE) == '0);
    endproperty
    a_pdown: assert property (p_pdown) else $error("powerdown pins not both released");
    property p_idle; !WR && !DRIVER_ENABLED[0] ##1 !DRIVER_ENABLED[0] |-> $stable(OUT_TRUE[0]);
    endproperty
    a_idle: assert property (p_idle) else $error("disabled output not static");
    property p_diff; DIFF_FORMAT[0] && OUT_TRUE_OE[0] |-> COMPLEMENT_OUTPUT_PIN[0] != OUT_TRUE[0];
    endproperty
    a_diff: assert property (p_diff) else $error("differential pins not complementary");
    property p_skew; !cfg_rst |=> $stable(DIVIDER_SKEW_SETTING); endproperty
    a_skew: assert property (p_skew) else $error("delay changed without reset");
    property p_step; !cfg_rst && !(WR && ADDR == ADDR_STEP) |=> $stable(DIVIDER_PHASE_STEPS);
    endproperty
    a_step: assert property (p_step) else $error("step count changed unasked");
    property p_rdz; CLK_EN && !RD |=> RDATA == '0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside read slot");
    property p_status; s_rd_status |=> RDATA[NUM_OUT-1:0] == $past(DRIVER_ENABLED); endproperty
    a_status: assert property (p_status) else $error("status read mismatch");
endmodule : clock_output_enable_and_skew_chk
bind clock_output_enable_and_skew clock_output_enable_and_skew_chk #(.NUM_OUT(NUM_OUT),
    .NUM_DIV(NUM_DIV)) i_chk (.SYS_CLK, .RESET_N, .CLK_EN, .EXTERNAL_RESTART_PIN_N,
    .GLOBAL_OUTPUT_DISABLE_PIN, .DIFF_FORMAT, .ADDR, .WDATA, .WR, .RD, .RDATA, .OUT_TRUE,
    .OUT_TRUE_OE, .COMPLEMENT_OUTPUT_PIN, .COMPLEMENT_OUTPUT_PIN_OE, .DRIVER_ENABLED,
    .DIVIDER_SKEW_SETTING, .DIVIDER_PHASE_STEPS);

// ### div_clk_src.sv
`timescale 1ns/1ps
// divider clocks, period four system cycles, so sync gating has edges to wait for
module div_clk_src #(
    parameter int N = 12
) (
    input wire logic clk,
    output logic [N-1:0] div_clk
);
    logic [1:0] cnt = 2'h0;
    always_ff @(posedge clk) begin
        cnt <= cnt + 2'h1;
    end
    assign div_clk = {N{cnt[1]}};
endmodule : div_clk_src

// ### clock_output_enable_and_skew_tb.sv
`timescale 1ns/1ps
module clock_output_enable_and_skew_tb;
    import clk_out_pkg::*;
    logic clk = 0, rst_n = 0, rs_n = 1, gdis = 0, loop_unlocked_flag = 0, xl = 0, wr = 0, rd = 0, clk_en = 1;
    logic [11:0] dclk, dif = '0, en, ot, oe, co, coe;
    logic [7:0] addr = '0;
    logic [31:0] wd = '0, rdata;
    logic [63:0] skew, steps;
    int mismatches = 0, n_tests = 0;
    initial forever #4 clk = ~clk;
    div_clk_src i_div_clk_src (.clk(clk), .div_clk(dclk));
    clock_output_enable_and_skew i_clock_output_enable_and_skew (.SYS_CLK(clk),
        .RESET_N(rst_n), .CLK_EN(clk_en), .EXTERNAL_RESTART_PIN_N(rs_n),
        .GLOBAL_OUTPUT_DISABLE_PIN(gdis), .DIV_CLK(dclk), .FROM_LOOP_B('1), .DIFF_FORMAT(dif),
        .LOOP_UNLOCKED_FLAG(loop_unlocked_flag), .CRYSTAL_REF_LOSS_FAULT(xl), .ADDR(addr), .WDATA(wd),
        .WR(wr), .RD(rd), .RDATA(rdata), .OUT_TRUE(ot), .OUT_TRUE_OE(oe),
        .COMPLEMENT_OUTPUT_PIN(co), .COMPLEMENT_OUTPUT_PIN_OE(coe), .DRIVER_ENABLED(en),
        .DIVIDER_SKEW_SETTING(skew), .DIVIDER_PHASE_STEPS(steps));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(logic [11:0] seen, logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wd <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_chk(logic [7:0] a, logic [11:0] exp);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata[11:0], exp);
        @(posedge clk);
    endtask : rd_chk
    // bounded wait: a stuck driver state ends the run
    task automatic wait_en(logic [11:0] exp);
        for (int i = 0; i < 20 && en !== exp; i++) @(posedge clk);
        chk(en, exp);
        if (en !== exp) stop_test();
    endtask : wait_en
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd_chk(ADDR_ENABLE, 12'hfff);
        wait_en(12'hfff);
        rd_chk(ADDR_STATUS, 12'hfff);
        rd_chk(8'h10, 12'h000);
        gdis <= 1;
        wait_en(12'h000);
        repeat (8) @(posedge clk);
        chk(en, 12'h000);
        gdis <= 0;
        wait_en(12'hfff);
        $display("global disable done");
        xl <= 1;
        wait_en(12'h000);
        wr_reg(ADDR_AUTO_CTRL, 32'h0);
        wait_en(12'hfff);
        xl <= 0;
        loop_unlocked_flag <= 1;
        repeat (8) @(posedge clk);
        chk(en, 12'hfff);
        wr_reg(ADDR_AUTO_CTRL, 32'h1);
        wait_en(12'h000);
        loop_unlocked_flag <= 0;
        wr_reg(ADDR_AUTO_CTRL, 32'h2);
        $display("automatic disable done");
        wr_reg(ADDR_SYNC_GATE, 32'h0);
        wr_reg(ADDR_ENABLE, 32'hffe);
        chk(en, 12'hffe);
        wr_reg(ADDR_IDLE_LEVEL, 32'h1);
        chk(ot[0], 1'b1);
        wr_reg(ADDR_POWERDOWN, 32'h1);
        chk({oe[0], coe[0]}, 2'b00);
        wr_reg(ADDR_POWERDOWN, 32'h0);
        wr_reg(ADDR_ENABLE, 32'hfff);
        wr_reg(ADDR_SE_MODE, 32'h1);
        chk({ot[0], co[0]}, {2{dclk[0]}});
        wr_reg(ADDR_POL_COMP, 32'h1);
        chk({ot[0], co[0]}, {dclk[0], ~dclk[0]});
        wr_reg(ADDR_POL_TRUE, 32'h1);
        chk({ot[0], co[0]}, {~dclk[0], ~dclk[0]});
        dif <= 12'h001;
        @(posedge clk);
        chk({ot[0], co[0]}, {dclk[0], ~dclk[0]});
        clk_en <= 0;
        wr_reg(ADDR_ENABLE, 32'h0);
        clk_en <= 1;
        rd_chk(ADDR_ENABLE, 12'hfff);
        $display("output modes done");
        wr_reg(ADDR_DELAY0, 32'h5);
        chk(skew[11:0], 12'h000);
        wr_reg(ADDR_SOFT_RST, 32'h1);
        chk(skew[11:0], 12'h005);
        rd_chk(ADDR_ACTIVE0, 12'h005);
        wr_reg(ADDR_STEP, 32'h1);
        wr_reg(ADDR_STEP, 32'h1);
        wr_reg(ADDR_STEP, 32'h101);
        chk(steps[11:0], 12'h001);
        chk(steps[27:16], 12'h000);
        rs_n <= 0;
        repeat (2) @(posedge clk);
        rs_n <= 1;
        chk(skew[11:0], 12'h000);
        chk(steps[11:0], 12'h000);
        $display("skew done");
        stop_test();
    end
endmodule : clock_output_enable_and_skew_tb
